// [rtl/adcref_regs.sv]
// adcref_regs: reference and excitation-current configuration bank, APB slave
// How it works
// - monitor field selects four monitor settings
// - bit5 bypasses positive buffer, reset enabled
// - bit4 bypasses negative buffer, reset bypassed
// - source field picks ext0, ext1, internal
// - power field: off, on, always on
// - bit7 enables amplifier rail monitor
// - bit6 closes low switch, opens in power-down
// - four-bit magnitude drives both sources
// - upper nibble routes second source
// - lower nibble routes first source
//
// Added by the designer: the APB interface to the registers.
module adcref_regs
  import adcref_pkg::*;
#(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // analog-side status pins
  input wire logic POWER_DOWN_I,
  input wire logic REF_LOW_FLAG_I,
  input wire logic REF_THIRD_FLAG_I,
  input wire logic RAIL_FLAG_I,
  // reference control outputs
  output logic [1:0] REF_MONITOR_CFG_O,
  output logic POS_REF_BUFFER_BYPASS_O,
  output logic NEG_REF_BUFFER_BYPASS_O,
  output logic [1:0] REF_SOURCE_SELECT_O,
  output logic INTERNAL_REF_ON_O,
  // excitation outputs
  output logic AMP_RAIL_MONITOR_ENABLE_O,
  output logic LOW_SIDE_SWITCH_O,
  output logic [3:0] EXCITATION_MAGNITUDE_CODE_O,
  output logic [3:0] FIRST_SOURCE_ROUTE_O,
  output logic [3:0] SECOND_SOURCE_ROUTE_O,
  // interrupt
  output logic IRQ_O
);
  logic [7:0] ref_ctrl;
  logic [7:0] exc_mag;
  logic [7:0] exc_route;
  logic [2:0] flags_sync;
  logic [2:0] flags_prev;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic pd_sync;
  logic [31:0] next_prdata;

  // register decode; zero wait states so pready is tied high
  wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire lane0 = PSTRB_I[0];
  wire hit_ref = PADDR_I == ADDR_REF_CTRL;
  wire hit_mag = PADDR_I == ADDR_EXC_MAG;
  wire hit_route = PADDR_I == ADDR_EXC_ROUTE;
  wire hit_stat = PADDR_I == ADDR_IRQ_STATUS;
  wire hit_mask = PADDR_I == ADDR_IRQ_MASK;
  wire hit_mon = PADDR_I == ADDR_MON_STATUS;
  wire hit_any = hit_ref | hit_mag | hit_route | hit_stat | hit_mask | hit_mon;
  wire wr_ref = apb_wr & lane0 & hit_ref;
  wire wr_mag = apb_wr & lane0 & hit_mag;
  wire wr_route = apb_wr & lane0 & hit_route;
  wire wr_mask = apb_wr & lane0 & hit_mask;
  wire wr_stat = apb_wr & lane0 & hit_stat;
  // codes 11 are reserved in source and power fields; 9..15 in magnitude
  wire bad_code = (wr_ref & ((PWDATA_I[F_REF_SRC_HI:F_REF_SRC_LO] == SRC_RSVD)
                  | (PWDATA_I[F_INT_PWR_HI:F_INT_PWR_LO] == PWR_RSVD)))
                  | (wr_mag & (PWDATA_I[3:0] > MAG_MAX_CODE));

  assign PREADY_O = 1'b1;
  // unmapped addresses answer with an error and no side effect
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit_any;

  // configuration registers; reserved codes are stored as written and flagged
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ref_ctrl <= RST_REF_CTRL;
      exc_mag <= RST_EXC_MAG;
      exc_route <= RST_EXC_ROUTE;
    end else begin
      if (wr_ref) begin
        ref_ctrl <= PWDATA_I[7:0];
      end
      if (wr_mag) begin
        exc_mag <= PWDATA_I[7:0] & EXC_MAG_WMASK;
      end
      if (wr_route) begin
        exc_route <= PWDATA_I[7:0];
      end
    end
  end

  // pin levels cross into this clock before use
  adcref_sync #(.W(4)) u_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .d_i({POWER_DOWN_I, RAIL_FLAG_I, REF_THIRD_FLAG_I, REF_LOW_FLAG_I}),
    .q_o({pd_sync, flags_sync})
  );

  // rising-edge detect of monitor flags
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      flags_prev <= 3'h0;
    end else begin
      flags_prev <= flags_sync;
    end
  end

  // flags only count when their monitor is enabled
  assign irq_event[IRQ_REF_LOW] = flags_sync[0] & ~flags_prev[0]
                                  & (ref_ctrl[7:6] != MON_OFF);
  assign irq_event[IRQ_REF_THIRD] = flags_sync[1] & ~flags_prev[1]
                                    & (ref_ctrl[7:6] == MON_LOW_THIRD);
  // rail events gated by the enable bit
  assign irq_event[IRQ_RAIL] = flags_sync[2] & ~flags_prev[2] & exc_mag[F_RAIL_EN];
  assign irq_event[IRQ_BAD_CODE] = bad_code;
  assign irq_clear = wr_stat ? PWDATA_I[IRQ_W-1:0] : '0;

  adcref_irq #(.W(IRQ_W)) u_irq (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .event_i(irq_event),
    .clear_i(irq_clear),
    .mask_we_i(wr_mask),
    .mask_wdata_i(PWDATA_I[IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(IRQ_O)
  );

  // read mux, upper bits read zero
  always_comb begin
    next_prdata = 32'h0;
    if (hit_ref) next_prdata[7:0] = ref_ctrl;
    if (hit_mag) next_prdata[7:0] = exc_mag;
    if (hit_route) next_prdata[7:0] = exc_route;
    if (hit_stat) next_prdata[IRQ_W-1:0] = irq_status;
    if (hit_mask) next_prdata[IRQ_W-1:0] = irq_mask;
    if (hit_mon) next_prdata[3:0] = {pd_sync, flags_sync};
  end

  // read data registered in the setup cycle, valid in access phase
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      PRDATA_O <= next_prdata;
    end
  end

  // field outputs straight from the flops, except internal ref on and low switch, gated by power-down
  // reference fields out
  assign REF_MONITOR_CFG_O = ref_ctrl[F_REF_MON_HI:F_REF_MON_LO];
  assign POS_REF_BUFFER_BYPASS_O = ref_ctrl[F_POS_BYP];
  assign NEG_REF_BUFFER_BYPASS_O = ref_ctrl[F_NEG_BYP];
  assign REF_SOURCE_SELECT_O = ref_ctrl[F_REF_SRC_HI:F_REF_SRC_LO];
  // mode 01 drops out in power-down, mode 10 stays on
  assign INTERNAL_REF_ON_O = (ref_ctrl[1:0] == PWR_ALWAYS)
                             | ((ref_ctrl[1:0] == PWR_ON_PD_OFF) & ~pd_sync);
  assign AMP_RAIL_MONITOR_ENABLE_O = exc_mag[F_RAIL_EN];
  assign LOW_SIDE_SWITCH_O = exc_mag[F_LOW_SW] & ~pd_sync;
  assign EXCITATION_MAGNITUDE_CODE_O = exc_mag[3:0];
  assign FIRST_SOURCE_ROUTE_O = exc_route[3:0];
  assign SECOND_SOURCE_ROUTE_O = exc_route[7:4];

  // checks; all on the bus clock, quiet while reset is held
  // apb read setup followed by its access phase
  sequence s_setup_read;
    PSEL_I && !PENABLE_I && !PWRITE_I;
  endsequence
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  // monitor flag rising while its monitor is enabled
  sequence s_low_rise;
    $rose(flags_sync[0]) && (ref_ctrl[7:6] != 2'b00);
  endsequence
  sequence s_third_rise;
    $rose(flags_sync[1]) && (ref_ctrl[7:6] == 2'b10);
  endsequence
  sequence s_rail_rise;
    $rose(flags_sync[2]) && exc_mag[7];
  endsequence

  a_refctl_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> ref_ctrl == 8'h10)
    else $error("reference control reset value wrong");

  a_posbyp_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> !POS_REF_BUFFER_BYPASS_O)
    else $error("positive bypass set after reset");

  a_mon_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> REF_MONITOR_CFG_O == 2'b00)
    else $error("monitor enabled after reset");

  a_route_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> FIRST_SOURCE_ROUTE_O == 4'hf)
    else $error("first route reset wrong");

  a_second_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> SECOND_SOURCE_ROUTE_O == 4'hf)
    else $error("second route reset wrong");

  a_mag_reset: assert property (@(posedge CLK_I)
    $fell(SRST_I) |-> exc_mag == 8'h00)
    else $error("magnitude register reset wrong");

  a_ref_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_ref |=> ref_ctrl == $past(PWDATA_I[7:0]))
    else $error("ref write lost");

  a_ref_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wr_ref |=> $stable(ref_ctrl))
    else $error("reference control changed without a write");

  a_src_out: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wr_ref |=> $stable(REF_SOURCE_SELECT_O))
    else $error("source select changed without a write");

  a_src_reserved: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_ref && (PWDATA_I[3:2] == 2'b11) |=> irq_status[IRQ_BAD_CODE])
    else $error("reserved source code not flagged");

  a_intref_on: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (ref_ctrl[1:0] == 2'b00) |-> !INTERNAL_REF_ON_O)
    else $error("ref on when off");

  a_intref_always: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (ref_ctrl[1:0] == 2'b10) |-> INTERNAL_REF_ON_O)
    else $error("always-on reference dropped");

  a_intref_pd: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (ref_ctrl[1:0] == 2'b01) |-> INTERNAL_REF_ON_O == !pd_sync)
    else $error("reference does not follow power-down");

  a_third_gate: assert property (@(posedge CLK_I) disable iff (SRST_I)
    (ref_ctrl[7:6] != 2'b10) |-> !irq_event[IRQ_REF_THIRD])
    else $error("third-supply event while disabled");

  a_low_event: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_low_rise |=> irq_status[IRQ_REF_LOW])
    else $error("low reference event lost");

  a_third_event: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_third_rise |=> irq_status[IRQ_REF_THIRD])
    else $error("third-supply event lost");

  a_rail_gate: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !exc_mag[F_RAIL_EN] |-> !irq_event[IRQ_RAIL])
    else $error("rail event while off");

  a_rail_event: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_rail_rise |=> irq_status[IRQ_RAIL])
    else $error("rail event lost");

  a_switch_pd: assert property (@(posedge CLK_I) disable iff (SRST_I)
    pd_sync |-> !LOW_SIDE_SWITCH_O)
    else $error("switch closed in power-down");

  a_switch_follow: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !pd_sync |-> LOW_SIDE_SWITCH_O == exc_mag[F_LOW_SW])
    else $error("switch does not follow its bit");

  a_mag_reserved: assert property (@(posedge CLK_I) disable iff (SRST_I)
    exc_mag[5:4] == 2'b00)
    else $error("reserved magnitude bits set");

  a_read_data: assert property (@(posedge CLK_I) disable iff (SRST_I)
    s_setup_read ##1 s_access |-> PRDATA_O == $past(next_prdata))
    else $error("read data not the word selected in setup");

  a_mag_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_mag |=> EXCITATION_MAGNITUDE_CODE_O == $past(PWDATA_I[3:0]))
    else $error("magnitude write lost");

  a_mag_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wr_mag |=> $stable(exc_mag))
    else $error("magnitude changed without a write");

  a_mag_too_big: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_mag && (PWDATA_I[3:0] > 4'h8) |=> irq_status[IRQ_BAD_CODE])
    else $error("oversize magnitude not flagged");

  a_route_split: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_route |=> {SECOND_SOURCE_ROUTE_O, FIRST_SOURCE_ROUTE_O} == $past(PWDATA_I[7:0]))
    else $error("routing nibbles wrong");

  a_route_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wr_route |=> $stable(exc_route))
    else $error("routing changed without a write");

  // status cleared by software unless a new event lands
  a_w1c_clear: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wr_stat |=> (irq_status & $past(PWDATA_I[IRQ_W-1:0] & ~irq_event)) == '0)
    else $error("status bit survived its clear");

endmodule // adcref_regs

// [common/adcref_pkg.sv]
// adcref_pkg: register map, field layout and reset values of the reference/excitation bank
package adcref_pkg;
  // register offsets: printed offsets 0x05..0x07 are not all multiples of four,
  // so they are indices and the byte address is four times the index
  localparam logic [7:0] IDX_REF_CTRL = 8'h05;
  localparam logic [7:0] IDX_EXC_MAG = 8'h06;
  localparam logic [7:0] IDX_EXC_ROUTE = 8'h07;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_MON_STATUS = 8'h0a;
  localparam logic [11:0] ADDR_REF_CTRL = 12'h014;
  localparam logic [11:0] ADDR_EXC_MAG = 12'h018;
  localparam logic [11:0] ADDR_EXC_ROUTE = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h024;
  localparam logic [11:0] ADDR_MON_STATUS = 12'h028;
  // reset values
  localparam logic [7:0] RST_REF_CTRL = 8'h10;
  localparam logic [7:0] RST_EXC_MAG = 8'h00;
  localparam logic [7:0] RST_EXC_ROUTE = 8'hff;
  localparam logic [3:0] RST_IRQ = 4'h0;
  // reference control fields
  localparam int F_REF_MON_HI = 7;
  localparam int F_REF_MON_LO = 6;
  localparam int F_POS_BYP = 5;
  localparam int F_NEG_BYP = 4;
  localparam int F_REF_SRC_HI = 3;
  localparam int F_REF_SRC_LO = 2;
  localparam int F_INT_PWR_HI = 1;
  localparam int F_INT_PWR_LO = 0;
  // excitation magnitude fields
  localparam int F_RAIL_EN = 7;
  localparam int F_LOW_SW = 6;
  localparam logic [7:0] EXC_MAG_WMASK = 8'hcf;
  localparam logic [3:0] MAG_MAX_CODE = 4'h8;
  // interrupt status bits
  localparam int IRQ_REF_LOW = 0;
  localparam int IRQ_REF_THIRD = 1;
  localparam int IRQ_RAIL = 2;
  localparam int IRQ_BAD_CODE = 3;
  localparam int IRQ_W = 4;
  // monitor modes
  typedef enum logic [1:0] {
    MON_OFF = 2'b00,
    MON_LOW = 2'b01,
    MON_LOW_THIRD = 2'b10,
    MON_LOW_PULL = 2'b11
  } adcref_mon_t;
  // reference source codes
  typedef enum logic [1:0] {
    SRC_EXT0 = 2'b00,
    SRC_EXT1 = 2'b01,
    SRC_INT = 2'b10,
    SRC_RSVD = 2'b11
  } adcref_src_t;
  // internal reference power codes
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_ON_PD_OFF = 2'b01,
    PWR_ALWAYS = 2'b10,
    PWR_RSVD = 2'b11
  } adcref_pwr_t;
endpackage

// [rtl/adcref_sync.sv]
// adcref_sync: two-flop synchroniser for a vector of pin levels
module adcref_sync
  import adcref_pkg::*;
#(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] stage1;

  // first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule // adcref_sync

// [rtl/adcref_irq.sv]
// adcref_irq: sticky event bits, write-one-to-clear, masked level interrupt
module adcref_irq
  import adcref_pkg::*;
#(
  parameter int W = IRQ_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // events and software access
  input wire logic [W-1:0] event_i,
  input wire logic [W-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [W-1:0] mask_wdata_i,
  // state
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);
  logic [W-1:0] next_status;

  // set wins over a clear in the same cycle
  assign next_status = (status_o & ~clear_i) | event_i;

  // status and mask flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_o <= W'(RST_IRQ);
      mask_o <= W'(RST_IRQ);
    end else begin
      status_o <= next_status;
      if (mask_we_i) begin
        mask_o <= mask_wdata_i;
      end
    end
  end

  // level interrupt, mask bit set means enabled
  assign irq_o = |(status_o & mask_o);
endmodule // adcref_irq

// [tb/adcref_host.sv]
// host controller model: apb master that configures the bank
module adcref_host (
  // clock
  input wire logic clk_i,
  // apb master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    pstrb_o = 4'h0;
  end
  // one transfer; request held until pready is seen high at an edge, or 16 edges pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= {24'h0, d};
    pstrb_o <= 4'h1;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 16);
    hung = (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // adcref_host

// [tb/tb_top.sv]
// self-checking bench for the reference/excitation register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pd = 1'b0;
  logic [2:0] fl = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, pbyp, nbyp, ion, rail_en, lsw, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, mag, r1, r2;
  logic [1:0] mon, src;
  int failures = 0;
  int checks_done = 0;
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  adcref_regs dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .POWER_DOWN_I(pd),
    .REF_LOW_FLAG_I(fl[0]), .REF_THIRD_FLAG_I(fl[1]), .RAIL_FLAG_I(fl[2]),
    .REF_MONITOR_CFG_O(mon), .POS_REF_BUFFER_BYPASS_O(pbyp), .NEG_REF_BUFFER_BYPASS_O(nbyp),
    .REF_SOURCE_SELECT_O(src), .INTERNAL_REF_ON_O(ion), .AMP_RAIL_MONITOR_ENABLE_O(rail_en),
    .LOW_SIDE_SWITCH_O(lsw), .EXCITATION_MAGNITUDE_CODE_O(mag), .FIRST_SOURCE_ROUTE_O(r1),
    .SECOND_SOURCE_ROUTE_O(r2), .IRQ_O(irq));
  adcref_host host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));
  // verdict, reached from the main flow or a hung transfer
  task automatic conclude();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus access; outputs sampled at the falling edge once updates settle
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
    logic h;
    host.xfer(w, a, d, r, e, h);
    if (h !== 1'b0) begin
      failures++;
      conclude();
    end else begin
      @(negedge clk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    acc(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, x});
  endtask
  // pin levels; five edges covers the two-flop sync plus event latency
  task automatic pins(input logic p, input logic [2:0] f);
    @(posedge clk);
    pd <= p;
    fl <= f;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    rd(12'h014, 8'h10);
    rd(12'h018, 8'h00);
    rd(12'h01c, 8'hff);
    chk({mon, pbyp, nbyp, src}, 6'h04);
    chk({ion, rail_en, lsw, mag}, 7'h00);
    chk({r2, r1, irq}, 9'h1fe);
  endtask
  task automatic t_ref();
    for (int k = 0; k < 4; k++) begin
      // both buffers bypassed whenever the internal source is picked
      wr(12'h014, {k[1:0], ~k[0], k[1], k[1:0], 2'b00});
      chk({mon, pbyp, nbyp, src}, {k[1:0], ~k[0], k[1], k[1:0]});
    end
    // internal source always on, both buffers bypassed by the host
    wr(12'h014, 8'h3a);
    chk({pbyp, nbyp, src, ion}, 5'h1d);
    pins(1'b1, 3'h0);
    chk(ion, 1'b1);
    rd(12'h028, 8'h08);
    wr(12'h014, 8'h39);
    chk(ion, 1'b0);
    pins(1'b0, 3'h0);
    chk(ion, 1'b1);
    rd(12'h014, 8'h39);
  endtask
  task automatic t_exc();
    // reference already on before any nonzero magnitude
    wr(12'h018, 8'hff);
    rd(12'h018, 8'hcf);
    chk({rail_en, lsw, mag}, 6'h3f);
    pins(1'b1, 3'h0);
    chk(lsw, 1'b0);
    pins(1'b0, 3'h0);
    chk(lsw, 1'b1);
    wr(12'h018, 8'h88);
    chk({rail_en, lsw, mag}, 6'h28);
    wr(12'h01c, 8'ha5);
    chk({r2, r1}, 8'ha5);
    rd(12'h01c, 8'ha5);
  endtask
  task automatic t_irq();
    logic [31:0] r;
    logic e;
    rd(12'h020, 8'h08);
    chk(irq, 1'b0);
    wr(12'h024, 8'h0f);
    chk(irq, 1'b1);
    wr(12'h020, 8'h08);
    chk(irq, 1'b0);
    for (int i = 0; i < 3; i++) begin
      // reference kept on while the magnitude is nonzero
      wr(12'h014, (i == 1) ? 8'h92 : 8'h52);
      pins(1'b0, 3'b001 << i);
      rd(12'h020, 8'h01 << i);
      chk(irq, 1'b1);
      pins(1'b0, 3'h0);
      wr(12'h020, 8'h01 << i);
      chk(irq, 1'b0);
    end
    // a write leaves read data at the last word read (status bit 2)
    acc(1'b1, 12'h030, 8'hff, r, e);
    chk({e, r}, 33'h100000004);
    acc(1'b0, 12'h030, 8'h00, r, e);
    chk({e, r}, 33'h100000000);
  endtask
  // reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_ref();
    t_exc();
    t_irq();
    conclude();
  end
endmodule // tb_top
